// ==== design/cpm_core_regs.sv ====
// Core programming model: register sets, privilege, addressing
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - State moves and returns flush and refetch prefetch; bus state writes do not
// - Sixteen 32-bit registers, pointer, flag byte
// - Five supervisor registers, supervisor access only
// - Eight data, eight address; last is stack
// - Any register selectable as index
// - Instruction pointer holds executing instruction address
// - Flag byte user-visible, feeds condition tests
// - High state byte holds privilege, supervisor-only
// - Table base keeps top 12 bits
// - Cache control word enables instruction cache
// - Two windows mark regions noncacheable
// - Two's complement arithmetic, signed or unsigned
// - Operand size explicit or implied
// - Bit, byte, word and longword sizes
// - Eight addressing mode groups
// - Indirect: plain, postinc, predec, d16, indexed
// - Relative d16 and indexed d8 forms
// - Index value scaled before the sum
// - Exception saves state word, forces supervisor
module cpm_core_regs
   import cpm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Register read and write ports
   input wire logic [3:0] rd_sel_a,
   input wire logic [3:0] rd_sel_b,
   output logic [31:0] rd_data_a,
   output logic [31:0] rd_data_b,
   input wire logic wr_en,
   input wire logic [3:0] wr_sel,
   input wire logic [1:0] wr_size,
   input wire logic [31:0] wr_data,
   // Operand size decode
   input wire logic size_explicit,
   input wire logic [1:0] size_field,
   input wire logic [1:0] size_implied,
   output logic [1:0] op_size,
   // Flags, control and state word
   input wire logic flags_wr,
   input wire logic [7:0] flags_in,
   output logic [7:0] condition_flag_byte,
   input wire logic ctl_wr,
   input wire logic [2:0] ctl_sel,
   input wire logic [31:0] ctl_data,
   input wire logic state_wr,
   input wire logic [15:0] state_data,
   input wire logic ret_en,
   input wire logic [15:0] ret_state,
   input wire logic [31:0] ret_pc,
   output logic supervisor,
   output logic fetch_flush,
   output logic priv_violation,
   // Instruction pointer
   input wire logic pc_load,
   input wire logic [31:0] pc_in,
   output logic [31:0] instruction_pointer,
   // Exception entry
   input wire logic exc_enter,
   input wire logic [7:0] exc_vector,
   output logic [15:0] exc_saved_state,
   output logic [31:0] exc_vector_addr,
   output logic [31:0] exc_stack_addr,
   output logic exc_ready,
   // Cache steering
   input wire logic [31:0] fetch_addr,
   output logic icache_enable,
   output logic fetch_noncacheable,
   // Effective address generator
   input wire logic ea_req,
   input wire logic [2:0] ea_mode,
   input wire logic [2:0] ea_reg,
   input wire logic [1:0] ea_size,
   input wire logic [15:0] ea_ext,
   input wire logic [31:0] ea_abs,
   output logic ea_valid,
   output logic ea_is_reg,
   output logic ea_is_imm,
   output logic [31:0] ea_addr,
   output logic [31:0] ea_value
);
   // ==========================================
   // State
   logic [31:0] gpr [16];
   logic [15:0] state_reg;
   logic [31:0] vtb_reg;
   logic [31:0] cache_reg;
   logic [31:0] win0_reg;
   logic [31:0] win1_reg;
   logic [31:0] viol_reg;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic aw_priv;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // ==========================================
   // Privilege and control decode
   wire user_mode = ~state_reg[SUPV_BIT];
   wire ctl_bad = ctl_wr & user_mode;
   wire state_bad = state_wr & user_mode;
   wire ctl_ok = ctl_wr & ~user_mode;
   wire state_ok = state_wr & ~user_mode & ~exc_enter;
   wire ret_ok = ret_en & ~user_mode & ~exc_enter & ~state_wr;

   // ==========================================
   // Bus write decode
   wire wr_go = aw_held & w_held & ~s_axi_bvalid;
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire a_gpr = aw_addr[7:6] == OFS_GPR[7:6];
   wire a_flags = aw_addr == OFS_FLAGS;
   wire a_sup = (aw_addr == OFS_STATE) | (aw_addr == OFS_VTB) | (aw_addr == OFS_CACHE)
      | (aw_addr == OFS_WIN0) | (aw_addr == OFS_WIN1);
   wire a_ro = (aw_addr == OFS_IPTR) | (aw_addr == OFS_VIOL);
   wire bus_sup_ok = wr_go & a_sup & aw_priv;
   wire [1:0] wr_resp = (a_gpr | a_flags | a_ro) ? RESP_OKAY
      : a_sup ? (aw_priv ? RESP_OKAY : RESP_SLVERR) : RESP_DECERR;
   wire bus_flags = wr_go & a_flags;
   wire bus_state = bus_sup_ok & (aw_addr == OFS_STATE);
   wire [31:0] bus_merge_state = ({16'h0000, state_reg} & ~wmask) | (w_data & wmask);

   // ==========================================
   // Bus read decode
   wire [7:0] ra = s_axi_araddr;
   wire r_gpr = ra[7:6] == OFS_GPR[7:6];
   wire r_sup = (ra == OFS_STATE) | (ra == OFS_VTB) | (ra == OFS_CACHE)
      | (ra == OFS_WIN0) | (ra == OFS_WIN1);
   wire r_open = r_gpr | (ra == OFS_IPTR) | (ra == OFS_FLAGS) | (ra == OFS_VIOL);
   wire r_deny = r_sup & ~s_axi_arprot[0];
   wire [31:0] rd_mux = r_gpr ? gpr[ra[5:2]]
      : r_deny ? 32'h00000000
      : (ra == OFS_STATE) ? {16'h0000, state_reg}
      : (ra == OFS_VTB) ? vtb_reg
      : (ra == OFS_CACHE) ? cache_reg
      : (ra == OFS_WIN0) ? win0_reg
      : (ra == OFS_WIN1) ? win1_reg
      : (ra == OFS_IPTR) ? instruction_pointer
      : (ra == OFS_FLAGS) ? {24'h000000, state_reg[7:0]}
      : (ra == OFS_VIOL) ? viol_reg : 32'h00000000;
   wire [1:0] rd_resp = r_deny ? RESP_SLVERR : (r_open | r_sup) ? RESP_OKAY : RESP_DECERR;
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

   // ==========================================
   // Effective address arithmetic
   wire ext_m = ea_mode == EA_EXT;
   wire [31:0] x_raw = gpr[{ea_ext[XW_DA], ea_ext[XW_REG_HI -: 3]}];
   wire [31:0] x_val = ea_ext[XW_LONG] ? x_raw : {{16{x_raw[15]}}, x_raw[15:0]};
   // Index scaled by 1, 2, 4, 8
   wire [31:0] x_sc = x_val << ea_ext[XW_SC_HI:XW_SC_LO];
   wire [31:0] d8 = {{24{ea_ext[7]}}, ea_ext[7:0]};
   wire [31:0] d16 = {{16{ea_ext[15]}}, ea_ext};
   wire [31:0] an = gpr[{1'b1, ea_reg}];
   wire is_sp = {1'b1, ea_reg} == SP_INDEX;
   wire [31:0] step = (ea_size == SZ_LONG) ? 32'h00000004
      : (ea_size == SZ_WORD) ? 32'h00000002
      : (is_sp ? 32'h00000002 : 32'h00000001);
   wire ea_upd = ea_req & ((ea_mode == EA_POSTINC) | (ea_mode == EA_PREDEC));
   wire [31:0] an_new = (ea_mode == EA_POSTINC) ? an + step : an - step;
   wire [31:0] ea_sum = (ea_mode == EA_IND) || (ea_mode == EA_POSTINC) ? an
      : (ea_mode == EA_PREDEC) ? an_new
      : (ea_mode == EA_DISP16) ? an + d16
      : (ea_mode == EA_INDEX) ? an + d8 + x_sc
      : (ea_reg == EX_ABS_W) ? {{16{ea_abs[15]}}, ea_abs[15:0]}
      : (ea_reg == EX_ABS_L) ? ea_abs
      : (ea_reg == EX_PC_D16) ? instruction_pointer + 32'h00000002 + d16
      : (ea_reg == EX_PC_IDX) ? instruction_pointer + 32'h00000002 + d8 + x_sc
      : 32'h00000000;
   wire ea_dir = (ea_mode == EA_DREG) | (ea_mode == EA_AREG);
   wire ea_imm = ext_m & (ea_reg == EX_IMM);
   wire [31:0] dir_val = gpr[{ea_mode[0], ea_reg}];

   // ==========================================
   // Cache window match
   function automatic logic win_hit(input logic [31:0] w, input logic [31:0] a);
      win_hit = w[WIN_EN_BIT] & (((a[31:24] ^ w[31:24]) & ~w[23:16]) == 8'h00);
   endfunction
   wire nc_hit = win_hit(win0_reg, fetch_addr) | win_hit(win1_reg, fetch_addr);

   // ==========================================
   // Size-aware merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [1:0] s);
      case (s)
         SZ_BYTE: merge = {o[31:8], d[7:0]};
         SZ_WORD: merge = {o[31:16], d[15:0]};
         SZ_BIT: merge = {o[31:1], d[0]};
         default: merge = d;
      endcase
   endfunction

   // ==========================================
   // General registers
   // Sixteen 32-bit registers
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_gpr
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               gpr[gi] <= 32'h00000000;
            end else if (ce) begin
               if (wr_en && wr_sel == gi) begin
                  gpr[gi] <= merge(gpr[gi], wr_data, wr_size);
               end else if (ea_upd && {1'b1, ea_reg} == gi) begin
                  gpr[gi] <= an_new;
               end else if (wr_go && a_gpr && aw_addr[5:2] == gi) begin
                  gpr[gi] <= (gpr[gi] & ~wmask) | (w_data & wmask);
               end
            end
         end
      end
   endgenerate

   // ==========================================
   // State word, control registers, pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= STATE_RESET;
         vtb_reg <= 32'h00000000;
         cache_reg <= 32'h00000000;
         win0_reg <= 32'h00000000;
         win1_reg <= 32'h00000000;
         instruction_pointer <= 32'h00000000;
         viol_reg <= 32'h00000000;
      end else if (ce) begin
         if (exc_enter) begin
            state_reg[SUPV_BIT] <= 1'b1;
         end else if (state_ok) begin
            state_reg <= state_data & STATE_WMASK;
         end else if (ret_ok) begin
            state_reg <= ret_state & STATE_WMASK;
         end else if (flags_wr) begin
            state_reg[7:0] <= flags_in & STATE_WMASK[7:0];
         end else if (bus_state) begin
            state_reg <= bus_merge_state[15:0] & STATE_WMASK;
         end else if (bus_flags) begin
            state_reg[7:0] <= w_data[7:0] & STATE_WMASK[7:0];
         end
         if (ctl_ok && ctl_sel == 3'h1) begin
            vtb_reg <= ctl_data & VTB_MASK;
         end else if (bus_sup_ok && aw_addr == OFS_VTB) begin
            vtb_reg <= ((vtb_reg & ~wmask) | (w_data & wmask)) & VTB_MASK;
         end
         if (ctl_ok && ctl_sel == 3'h2) begin
            cache_reg <= ctl_data;
         end else if (bus_sup_ok && aw_addr == OFS_CACHE) begin
            cache_reg <= (cache_reg & ~wmask) | (w_data & wmask);
         end
         if (ctl_ok && ctl_sel == 3'h3) begin
            win0_reg <= ctl_data;
         end else if (bus_sup_ok && aw_addr == OFS_WIN0) begin
            win0_reg <= (win0_reg & ~wmask) | (w_data & wmask);
         end
         if (ctl_ok && ctl_sel == 3'h4) begin
            win1_reg <= ctl_data;
         end else if (bus_sup_ok && aw_addr == OFS_WIN1) begin
            win1_reg <= (win1_reg & ~wmask) | (w_data & wmask);
         end
         if (ret_ok) begin
            instruction_pointer <= ret_pc;
         end else if (pc_load) begin
            instruction_pointer <= pc_in;
         end
         if (ctl_bad || state_bad) begin
            viol_reg <= viol_reg + 32'h00000001;
         end
      end
   end

   // ==========================================
   // Core-facing registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data_a <= 32'h00000000;
         rd_data_b <= 32'h00000000;
         op_size <= SZ_LONG;
         fetch_flush <= 1'b0;
         priv_violation <= 1'b0;
         exc_saved_state <= 16'h0000;
         exc_vector_addr <= 32'h00000000;
         exc_stack_addr <= 32'h00000000;
         exc_ready <= 1'b0;
         icache_enable <= 1'b0;
         fetch_noncacheable <= 1'b0;
      end else if (ce) begin
         rd_data_a <= gpr[rd_sel_a];
         rd_data_b <= gpr[rd_sel_b];
         op_size <= size_explicit ? size_field : size_implied;
         fetch_flush <= state_ok | ret_ok;
         priv_violation <= ctl_bad | state_bad;
         exc_ready <= exc_enter;
         if (exc_enter) begin
            exc_saved_state <= state_reg;
            exc_vector_addr <= vtb_reg + {22'h000000, exc_vector, 2'h0};
            exc_stack_addr <= gpr[SP_INDEX] - 32'h00000004;
         end
         icache_enable <= cache_reg[CACHE_EN_BIT];
         fetch_noncacheable <= nc_hit;
      end
   end
   assign supervisor = state_reg[SUPV_BIT];
   assign condition_flag_byte = state_reg[7:0];

   // ==========================================
   // Address generator outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ea_valid <= 1'b0;
         ea_is_reg <= 1'b0;
         ea_is_imm <= 1'b0;
         ea_addr <= 32'h00000000;
         ea_value <= 32'h00000000;
      end else if (ce) begin
         ea_valid <= ea_req;
         if (ea_req) begin
            ea_is_reg <= ea_dir;
            ea_is_imm <= ea_imm;
            ea_addr <= ea_dir ? 32'h00000000 : ea_sum;
            ea_value <= ea_dir ? dir_val : ea_imm ? ea_abs : 32'h00000000;
         end
      end
   end

   // ==========================================
   // AXI4-Lite slave
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         aw_priv <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'h0};
            aw_priv <= s_axi_awprot[0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= rd_go & ~s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // cpm_core_regs
`default_nettype wire

// ==== design/cpm_pkg.sv ====
// Constants for the core programming model register file
package cpm_pkg;
   // ==========================================
   // Operand sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [1:0] SZ_BIT = 2'h3;
   // ==========================================
   // Effective address mode field
   localparam logic [2:0] EA_DREG = 3'h0;
   localparam logic [2:0] EA_AREG = 3'h1;
   localparam logic [2:0] EA_IND = 3'h2;
   localparam logic [2:0] EA_POSTINC = 3'h3;
   localparam logic [2:0] EA_PREDEC = 3'h4;
   localparam logic [2:0] EA_DISP16 = 3'h5;
   localparam logic [2:0] EA_INDEX = 3'h6;
   localparam logic [2:0] EA_EXT = 3'h7;
   // Register field when mode is EA_EXT
   localparam logic [2:0] EX_ABS_W = 3'h0;
   localparam logic [2:0] EX_ABS_L = 3'h1;
   localparam logic [2:0] EX_PC_D16 = 3'h2;
   localparam logic [2:0] EX_PC_IDX = 3'h3;
   localparam logic [2:0] EX_IMM = 3'h4;
   // Extension word fields
   localparam int XW_DA = 15;
   localparam int XW_REG_HI = 14;
   localparam int XW_LONG = 11;
   localparam int XW_SC_HI = 10;
   localparam int XW_SC_LO = 9;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] OFS_STATE = 8'h00;
   localparam logic [7:0] OFS_VTB = 8'h04;
   localparam logic [7:0] OFS_CACHE = 8'h08;
   localparam logic [7:0] OFS_WIN0 = 8'h0C;
   localparam logic [7:0] OFS_WIN1 = 8'h10;
   localparam logic [7:0] OFS_IPTR = 8'h14;
   localparam logic [7:0] OFS_FLAGS = 8'h18;
   localparam logic [7:0] OFS_VIOL = 8'h1C;
   localparam logic [7:0] OFS_GPR = 8'h40;
   // ==========================================
   // Field layouts and reset values
   localparam int SUPV_BIT = 13;
   localparam logic [15:0] STATE_WMASK = 16'hA71F;
   localparam logic [15:0] STATE_RESET = 16'h2700;
   localparam logic [31:0] VTB_MASK = 32'hFFF00000;
   localparam int CACHE_EN_BIT = 31;
   localparam int WIN_EN_BIT = 15;
   localparam logic [3:0] SP_INDEX = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ==== tb/cpm_core_regs_monitor.sv ====
// Concurrent checks on the programming model register file
`timescale 1ns/1ps
`default_nettype none
module cpm_core_regs_monitor
   import cpm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic state_wr,
   input wire logic exc_enter,
   input wire logic supervisor,
   input wire logic fetch_flush,
   input wire logic priv_violation,
   input wire logic exc_ready,
   input wire logic [15:0] exc_saved_state,
   input wire logic [7:0] condition_flag_byte,
   input wire logic size_explicit,
   input wire logic [1:0] size_field,
   input wire logic [1:0] size_implied,
   input wire logic [1:0] op_size,
   input wire logic ea_req,
   input wire logic [2:0] ea_mode,
   input wire logic [2:0] ea_reg,
   input wire logic ea_valid,
   input wire logic ea_is_reg,
   input wire logic ea_is_imm,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Privilege and fetch
   flush_pulse_a: assert property (ce && fetch_flush |=> !fetch_flush)
      else $error("flush pulse too long");
   flush_cause_a: assert property (ce && state_wr && supervisor && !exc_enter
      |=> fetch_flush)
      else $error("no flush after state move");
   user_refuse_a: assert property (ce && state_wr && !supervisor && !exc_enter
      |=> priv_violation && !supervisor)
      else $error("user state move not refused");
   exc_super_a: assert property (ce && exc_enter |=> supervisor && exc_ready)
      else $error("exception did not enter supervisor");
   exc_saved_a: assert property (ce && exc_enter |=>
      exc_saved_state[SUPV_BIT] == $past(supervisor)
      && exc_saved_state[7:0] == $past(condition_flag_byte))
      else $error("saved state word wrong");
   // ==========================================
   // Decode and address generation
   size_sel_a: assert property (ce && aresetn |=>
      op_size == ($past(size_explicit) ? $past(size_field) : $past(size_implied)))
      else $error("operand size wrong");
   ea_valid_a: assert property (ce |=> ea_valid == $past(ea_req))
      else $error("address valid not one edge after request");
   ea_kind_a: assert property (ce && ea_req |=> ea_is_reg == ($past(ea_mode) <= EA_AREG)
      && ea_is_imm == ($past(ea_mode) == EA_EXT && $past(ea_reg) == EX_IMM))
      else $error("address kind wrong");
   // Response must drop after its handshake, or a second write is seen twice
   bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
   cover property (exc_ready);
   cover property (fetch_flush);
   cover property (priv_violation);
endmodule // cpm_core_regs_monitor
bind cpm_core_regs cpm_core_regs_monitor cpm_core_regs_monitor_i (.*);
`default_nettype wire

// ==== tb/test_core_programming_model.sv ====
// Self-checking bench for the programming model register file
`timescale 1ns/1ps
`default_nettype none
module test_core_programming_model
   import cpm_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, wr_en = 1'h0;
   logic size_explicit = 1'h0, flags_wr = 1'h0, ctl_wr = 1'h0, state_wr = 1'h0, ret_en = 1'h0;
   logic pc_load = 1'h0, exc_enter = 1'h0, ea_req = 1'h0;
   logic [1:0] wr_size = '0, size_field = '0, size_implied = '0, ea_size = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, ctl_sel = '0, ea_mode = '0, ea_reg = '0;
   logic [3:0] s_axi_wstrb = 4'hF, rd_sel_a = '0, rd_sel_b = '0, wr_sel = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, flags_in = '0, exc_vector = '0;
   logic [15:0] state_data = '0, ret_state = '0, ea_ext = '0, xt;
   logic [31:0] s_axi_wdata = '0, wr_data = '0, ctl_data = '0, ret_pc = '0, pc_in = '0;
   logic [31:0] fetch_addr = '0, ea_abs = '0, v, a, e, x, d, p, vt, st;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supervisor;
   logic fetch_flush, priv_violation, exc_ready, icache_enable, fetch_noncacheable;
   logic ea_valid, ea_is_reg, ea_is_imm;
   logic [1:0] s_axi_bresp, s_axi_rresp, op_size, s;
   logic [2:0] md, rg;
   logic [7:0] condition_flag_byte;
   logic [15:0] exc_saved_state;
   logic [31:0] s_axi_rdata, rd_data_a, rd_data_b, instruction_pointer, exc_vector_addr;
   logic [31:0] exc_stack_addr, ea_addr, ea_value, seed = 32'h00013351;
   logic [31:0] m [16];
   int errors = 0, checks = 0, cyc = 0, i, k;
   cpm_core_regs cpm_core_regs_i (.*);
   // ==========================================
   // Clock, timeout and helpers
   initial begin
      forever #20 aclk = ~aclk;
   end
   // Whole run is a few hundred cycles; the ceiling only catches a hang
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         end_sim;
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task cy(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] dt, input logic pr, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awprot <= {2'h0, pr};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, r);
   endtask
   task rd(input logic [7:0] ad, input logic pr, input logic [31:0] dt, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arprot <= {2'h0, pr};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, dt);
      chk(s_axi_rresp, r);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      cy(12);
      aresetn <= 1'h1;
      cy(1);
      chk(supervisor, 1'h1);
      chk(op_size, SZ_LONG);
      rd(OFS_STATE, 1'h1, 32'h2700, RESP_OKAY);
      wr(OFS_CACHE, 32'h80000000, 1'h0, RESP_SLVERR);
      rd(OFS_CACHE, 1'h0, '0, RESP_SLVERR);
      cy(2);
      chk(icache_enable, 1'h0);
      wr(8'h30, '1, 1'h1, RESP_DECERR);
      rd(8'h30, 1'h1, '0, RESP_DECERR);
      wr(OFS_IPTR, '1, 1'h1, RESP_OKAY);
      rd(OFS_IPTR, 1'h1, '0, RESP_OKAY);
      vt = rnd();
      wr(OFS_VTB, vt, 1'h1, RESP_OKAY);
      rd(OFS_VTB, 1'h1, vt & VTB_MASK, RESP_OKAY);
      wr(OFS_CACHE, 32'h80000000, 1'h1, RESP_OKAY);
      cy(2);
      chk(icache_enable, 1'h1);
      for (i = 0; i < 2; i++) begin
         wr(i ? OFS_WIN1 : OFS_WIN0, 32'hA5008000, 1'h1, RESP_OKAY);
         fetch_addr <= 32'hA5123456;
         cy(2);
         chk(fetch_noncacheable, 1'h1);
         fetch_addr <= 32'h5A000000;
         cy(2);
         chk(fetch_noncacheable, 1'h0);
         wr(i ? OFS_WIN1 : OFS_WIN0, '0, 1'h1, RESP_OKAY);
      end
      p = rnd();
      pc_in <= p;
      pc_load <= 1'h1;
      cy(1);
      pc_load <= 1'h0;
      cy(1);
      chk(instruction_pointer, p);
      // First sixteen writes are long so byte and word merges see known data
      for (i = 0; i < 48; i++) begin
         k = i % 16;
         v = rnd();
         s = (i < 16) ? SZ_LONG : v[1:0];
         m[k] = (s == SZ_BYTE) ? {m[k][31:8], v[7:0]} : (s == SZ_WORD) ? {m[k][31:16], v[15:0]}
            : (s == SZ_BIT) ? {m[k][31:1], v[0]} : v;
         wr_sel <= 4'(k);
         wr_size <= s;
         wr_data <= v;
         wr_en <= 1'h1;
         size_explicit <= v[31];
         size_field <= v[30:29];
         size_implied <= v[28:27];
         cy(1);
      end
      wr_en <= 1'h0;
      cy(2);
      chk(op_size, v[31] ? v[30:29] : v[28:27]);
      for (k = 0; k < 16; k++) begin
         rd_sel_a <= 4'(k);
         rd_sel_b <= 4'(15 - k);
         cy(2);
         chk(rd_data_a, m[k]);
         chk(rd_data_b, m[15 - k]);
      end
      rd(OFS_GPR + 8'h3C, 1'h0, m[15], RESP_OKAY);
      for (i = 0; i < 60; i++) begin
         v = rnd();
         d = rnd();
         xt = v[15:0];
         md = v[18:16];
         rg = (md == EA_EXT) ? 3'(v[21:19] % 5) : v[21:19];
         s = 2'(v[23:22] % 3);
         a = m[8 + rg];
         st = (s == SZ_LONG) ? 32'h4 : (s == SZ_WORD || rg == 3'h7) ? 32'h2 : 32'h1;
         x = m[{xt[15], xt[14:12]}];
         if (!xt[11]) x = {{16{x[15]}}, x[15:0]};
         x = x << xt[10:9];
         case (md)
            EA_PREDEC: e = a - st;
            EA_DISP16: e = a + {{16{xt[15]}}, xt};
            EA_INDEX: e = a + {{24{xt[7]}}, xt[7:0]} + x;
            EA_EXT: e = (rg == EX_ABS_W) ? {{16{d[15]}}, d[15:0]} : (rg == EX_ABS_L) ? d
               : (rg == EX_PC_D16) ? p + 32'h2 + {{16{xt[15]}}, xt}
               : p + 32'h2 + {{24{xt[7]}}, xt[7:0]} + x;
            default: e = a;
         endcase
         if (md == EA_POSTINC) m[8 + rg] = a + st;
         if (md == EA_PREDEC) m[8 + rg] = e;
         ea_mode <= md;
         ea_reg <= rg;
         ea_size <= s;
         ea_ext <= xt;
         ea_abs <= d;
         ea_req <= 1'h1;
         cy(1);
         ea_req <= 1'h0;
         cy(1);
         if (md <= EA_AREG) chk({ea_is_reg, ea_value}, {1'h1, m[{md[0], rg}]});
         else if (md == EA_EXT && rg == EX_IMM) chk({ea_is_imm, ea_value}, {1'h1, d});
         else chk(ea_addr, e);
      end
      state_wr <= 1'h1;
      cy(1);
      state_wr <= 1'h0;
      cy(1);
      chk({fetch_flush, supervisor}, 2'h2);
      state_data <= 16'h2700;
      state_wr <= 1'h1;
      cy(1);
      state_wr <= 1'h0;
      ctl_sel <= 3'h1;
      ctl_data <= '1;
      ctl_wr <= 1'h1;
      cy(1);
      ctl_wr <= 1'h0;
      chk({priv_violation, supervisor, fetch_flush}, 3'h4);
      cy(1);
      chk(priv_violation, 1'h1);
      rd(OFS_VIOL, 1'h0, 32'h2, RESP_OKAY);
      flags_in <= 8'hFF;
      flags_wr <= 1'h1;
      cy(1);
      flags_wr <= 1'h0;
      cy(1);
      chk(condition_flag_byte, 8'h1F);
      exc_vector <= v[7:0];
      exc_enter <= 1'h1;
      cy(1);
      exc_enter <= 1'h0;
      cy(1);
      chk({exc_ready, supervisor, exc_saved_state}, 18'h3001F);
      chk(exc_vector_addr, (vt & VTB_MASK) + {22'h0, v[7:0], 2'h0});
      chk(exc_stack_addr, m[15] - 32'h4);
      ret_state <= 16'h2700;
      ret_pc <= d;
      ret_en <= 1'h1;
      cy(1);
      ret_en <= 1'h0;
      cy(1);
      chk({fetch_flush, supervisor, instruction_pointer}, {2'h3, d});
      end_sim;
   end
endmodule // test_core_programming_model
`default_nettype wire
